/* rtl/scsoc_pkg.sv */
// constants, field positions and types for the serial configuration / status / fuse block
// assumes a single 250 MHz system clock domain
package scsoc_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int CFG_BYTES = 16;
  localparam int ID_FUSE_BYTES = 3;
  localparam int FUSE_BYTES = 19;
  localparam int IDX_W = 5;

  localparam logic [6:0] A_RES = 7'h02;
  localparam logic [6:0] A_CFG4 = 7'h04;
  localparam logic [6:0] A_CFG5 = 7'h05;
  localparam logic [6:0] A_OEM_NIB = 7'h0A;
  localparam logic [6:0] A_OEM_B1 = 7'h0B;
  localparam logic [6:0] A_OEM_B2 = 7'h0C;
  localparam logic [6:0] A_SCRATCH = 7'h0D;
  localparam logic [6:0] A_TEST = 7'h0E;
  localparam logic [6:0] A_PROG = 7'h0F;
  localparam logic [6:0] A_MIRROR_LO = 7'h10;
  localparam logic [6:0] A_MIRROR_HI = 7'h1F;
  localparam logic [6:0] A_PROF0 = 7'h42;
  localparam logic [6:0] A_PROF1 = 7'h43;
  localparam logic [6:0] A_OPEN_LO = 7'h76;
  localparam logic [6:0] A_STATUS = 7'h77;
  localparam logic [6:0] A_ID_LO = 7'h78;
  localparam logic [6:0] A_TOS = 7'h7C;
  localparam logic [6:0] A_ID_WR_LO = 7'h7D;
  localparam logic [6:0] A_ID_HI = 7'h7F;

  localparam int B_PROT = 6;
  localparam int B_TOB = 4;
  localparam int B_TOS = 0;
  localparam int B_HC = 7;
  localparam int B_START = 0;
  localparam int B_OK = 0;
  localparam int B_SDATA = 1;
  localparam int B_AMAX = 2;
  localparam int B_AMIN = 3;
  localparam int B_EXT = 4;
  localparam int B_FAIL = 7;

  localparam logic [7:0] ERR_MASK = 8'h9E;
  localparam logic [7:0] DRIVE_MASK = 8'h8E;
  localparam logic [7:0] PROFILE_ID0 = 8'h2C;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [4:0] DATA_LENGTH_FIELD_MIN = 5'h02;
  localparam logic [4:0] DATA_LENGTH_FIELD_FULL = 5'h0A;

  localparam int CLK_NS = 4;
  localparam int TOUT_LONG_NS = 16000;
  localparam int TOUT_SHORT_NS = 2000;
  localparam logic [11:0] TOUT_LONG_CYC = 12'(TOUT_LONG_NS / CLK_NS);
  localparam logic [11:0] TOUT_SHORT_CYC = 12'(TOUT_SHORT_NS / CLK_NS);
  localparam int EXT_MASK_CYC = 3;

  typedef enum logic [1:0] {ZS_IDLE, ZS_PREP, ZS_PULSE, ZS_DONE} scsoc_zap_state_t;
endpackage

/* rtl/scsoc_zap_if.sv */
// handshake between register logic and the self-timed fuse programmer
// assumes both ends run on the system clock
`timescale 1ns/1ps
interface scsoc_zap_if;
  import scsoc_pkg::*;
  logic start;
  logic test_ok;
  logic supply_ok;
  logic [7:0] byte_q;
  logic busy;
  logic done;
  logic fail;
  logic strobe;
  logic [IDX_W-1:0] idx;
  logic [7:0] zdata;
  modport ctrl(output start, test_ok, supply_ok, byte_q,
               input busy, done, fail, strobe, idx, zdata);
  modport seq(input start, test_ok, supply_ok, byte_q,
              output busy, done, fail, strobe, idx, zdata);
endinterface

/* rtl/scsoc_sync.sv */
// two flip-flop synchroniser for asynchronous pins
// assumes the inputs are quasi-static levels relative to the clock
`timescale 1ns/1ps
module scsoc_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_reg <= '1;
      sync_out <= '1;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

/* rtl/scsoc_zap_seq.sv */
// self-timed fuse programming sequencer: walks every fusable byte once
// assumes the register side holds byte_q steady for the addressed index
`timescale 1ns/1ps
module scsoc_zap_seq #(
  parameter int ZAP_PULSE_CYC = 1000
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  scsoc_zap_if.seq zif
);
  import scsoc_pkg::*;
  scsoc_zap_state_t state_reg;
  logic [31:0] cnt_reg;
  logic fail_reg;
  logic done_reg;

  assign zif.busy = (state_reg != ZS_IDLE);
  assign zif.fail = fail_reg;
  assign zif.done = done_reg;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= ZS_IDLE;
      cnt_reg <= '0;
      fail_reg <= 1'b0;
      done_reg <= 1'b0;
      zif.strobe <= 1'b0;
      zif.idx <= '0;
      zif.zdata <= '0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        ZS_IDLE: begin
          // start is only seen here, so a running sequence ignores it
          if (zif.start) begin
            zif.idx <= '0;
            fail_reg <= !zif.supply_ok || !zif.test_ok;
            state_reg <= (zif.supply_ok && zif.test_ok) ? ZS_PREP : ZS_DONE;
          end
        end
        ZS_PREP: begin
          zif.zdata <= zif.byte_q;
          zif.strobe <= 1'b1;
          cnt_reg <= '0;
          state_reg <= ZS_PULSE;
        end
        ZS_PULSE: begin
          cnt_reg <= cnt_reg + 32'd1;
          if (!zif.supply_ok) begin
            fail_reg <= 1'b1;
          end
          if (cnt_reg == 32'(ZAP_PULSE_CYC - 1)) begin
            zif.strobe <= 1'b0;
            if (zif.idx == IDX_W'(FUSE_BYTES - 1)) begin
              state_reg <= ZS_DONE;
            end else begin
              zif.idx <= zif.idx + 1'b1;
              state_reg <= ZS_PREP;
            end
          end
        end
        ZS_DONE: begin
          done_reg <= 1'b1;
          state_reg <= ZS_IDLE;
        end
        default: state_reg <= ZS_IDLE;
      endcase
    end
  end

  sequence s_refused;
    zif.start && !(zif.supply_ok && zif.test_ok) && state_reg == ZS_IDLE;
  endsequence
  property p_refused_fails;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      s_refused |=> (state_reg == ZS_DONE) ##1 (done_reg && fail_reg);
  endproperty
  a_refused_fails: assert property (p_refused_fails) else $error("refused run not failed");

  property p_busy_ignores;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (zif.start && state_reg == ZS_PULSE && cnt_reg != 32'(ZAP_PULSE_CYC - 1)) |=>
        (state_reg == ZS_PULSE && $stable(zif.idx));
  endproperty
  a_busy_ignores: assert property (p_busy_ignores) else $error("start restarted a run");
endmodule

/* rtl/scsoc_top.sv */
// register side of the position sensor: status flags, timeout select, identifier,
// OEM data, fuse load / programming control and map protection
// assumes register requests come from the serial frame logic on clk_sys_in;
// the master clock, error pin and zap supply comparator are asynchronous pins
//
// Summary of operation
// - five error conditions each have their own sticky status bit
// - a fuse run that ends without success sets the failure flag
// - a position request before start-up completes sets the start-up data flag
// - amplitude above or below its limit sets its own flag
// - error pin pulled low from outside sets the external error flag
// - reading the status address clears all flags; next frame error bit inactive
// - timeout is 16 us with both fast bits 0, else 2 us
// - volatile fast timeout bit returns to 0 on every reset
// - a fused fast timeout bit forces the short timeout for good
// - 0x78-0x7B and 0x7D-0x7F hold the identifier (0x7C is timeout select); top three are writable and fusable
// - OEM nibble and bytes are fusable; scratch byte is never fused
// - readback bit selects high sense current for fuse mirror reads
// - writing 0x01 to 0x0F starts a run; start bit self-clears at end
// - success shows as success 1 and failure 0; other codes mean failure
// - unprotected: 0x00-0x0F and 0x7C-0x7F are readable and writable; 0x78-0x7B are read-only
// - fuse mirror and status register are read-only
// - protected: only 0x7C writable; only 0x42, 0x43, 0x76-0x7F readable
// - protection bit sits in configuration byte 0x05
// - at full resolution profile bytes read 0x2C and 0x0C
// - fuse contents are copied into RAM configuration after power-up
// - RAM configuration writes are ignored while protection is set
// - each frame carries a low-active error bit, 0 while an error flag pends
`timescale 1ns/1ps
module scsoc_top #(
  parameter int ZAP_PULSE_CYC = 1000,
  parameter logic [31:0] ID_FIXED = 32'h0123_4567  // arbitrary identifier bytes
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic [scsoc_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [scsoc_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [scsoc_pkg::DATA_W-1:0] reg_rdata_out,
  output logic reg_rvalid_out,
  input wire logic ma_clk_in,
  output logic frame_start_out,
  output logic frame_error_bit_out,
  output logic link_busy_out,
  output logic [11:0] timeout_cycles_out,
  input wire logic position_valid_in,
  input wire logic amp_high_in,
  input wire logic amp_low_in,
  input wire logic error_out_pin_in,
  output logic error_out_pin_out,
  output logic error_out_pin_oe_out,
  input wire logic zap_supply_ok_in,
  input wire logic [8*scsoc_pkg::FUSE_BYTES-1:0] fuse_rd_data_in,
  output logic fuse_high_current_out,
  output logic zap_strobe_out,
  output logic [scsoc_pkg::IDX_W-1:0] zap_index_out,
  output logic [scsoc_pkg::DATA_W-1:0] zap_data_out
);
  import scsoc_pkg::*;

  logic [7:0] ram_reg [0:CFG_BYTES-1];
  logic [7:0] id_reg [0:ID_FUSE_BYTES-1];
  logic tos_reg;
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] set_vec;
  logic load_done_reg;
  logic [2:0] sync_q;
  logic ma_s, err_pin_s, zap_ok_s;
  logic ma_d_reg;
  logic idle_reg;
  logic [11:0] cnt_reg;
  logic [EXT_MASK_CYC-1:0] oe_hist_reg;
  logic prot, wr_ok, readable, rd_status, startup_done, pos_req;
  logic [7:0] rd_word;
  logic [4:0] data_length_field;
  logic [11:0] tout_cyc;

  scsoc_zap_if zif ();

  scsoc_sync #(.W(3)) u_sync (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .async_in({ma_clk_in, error_out_pin_in, zap_supply_ok_in}),
    .sync_out(sync_q)
  );
  assign ma_s = sync_q[2];
  assign err_pin_s = sync_q[1];
  assign zap_ok_s = sync_q[0];

  scsoc_zap_seq #(.ZAP_PULSE_CYC(ZAP_PULSE_CYC)) u_zap (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .zif(zif.seq)
  );

  function automatic logic [4:0] data_length_field_of(input logic [7:0] res);
    data_length_field_of = DATA_LENGTH_FIELD_MIN;
    for (int i = 0; i < DATA_W - 1; i++) begin
      if (res[i]) begin
        data_length_field_of = DATA_LENGTH_FIELD_MIN + 5'(i) + 5'd1;
      end
    end
    if (res[DATA_W-1]) begin
      data_length_field_of = DATA_LENGTH_FIELD_FULL + {3'b000, res[1:0]};
    end
  endfunction

  assign prot = ram_reg[A_CFG5[3:0]][B_PROT];
  assign startup_done = load_done_reg && position_valid_in;
  assign data_length_field = data_length_field_of(ram_reg[A_RES[3:0]]);
  assign rd_status = reg_rd_in && (reg_addr_in == A_STATUS);

  // fused bit is read from the fuses themselves so a RAM overwrite cannot undo it
  assign tout_cyc = (tos_reg || ram_reg[A_CFG4[3:0]][B_TOB] ||
                     fuse_rd_data_in[8*A_CFG4 + B_TOB]) ?
                    TOUT_SHORT_CYC : TOUT_LONG_CYC;
  assign timeout_cycles_out = tout_cyc;

  // fuse programmer: bytes 0..15 from RAM configuration with 0x0D-0x0F sent as zero, then the three writable id bytes
  assign zif.start = reg_wr_in && wr_ok && reg_addr_in == A_PROG &&
                     reg_wdata_in[B_START];
  assign zif.test_ok = (ram_reg[A_TEST[3:0]] == BYTE_ZERO);
  assign zif.supply_ok = zap_ok_s;
  always_comb begin
    zif.byte_q = BYTE_ZERO;
    if (zif.idx < IDX_W'(CFG_BYTES)) begin
      if (zif.idx == A_OEM_NIB[IDX_W-1:0]) begin
        zif.byte_q = ram_reg[zif.idx[3:0]];
      end else if (zif.idx == A_SCRATCH[IDX_W-1:0] || zif.idx == A_TEST[IDX_W-1:0] ||
                   zif.idx == A_PROG[IDX_W-1:0]) begin
        zif.byte_q = BYTE_ZERO;
      end else begin
        zif.byte_q = ram_reg[zif.idx[3:0]];
      end
    end else if (zif.idx < IDX_W'(FUSE_BYTES)) begin
      zif.byte_q = id_reg[2'(zif.idx - IDX_W'(CFG_BYTES))];
    end
  end
  assign zap_strobe_out = zif.strobe;
  assign zap_index_out = zif.idx;
  assign zap_data_out = zif.zdata;
  assign fuse_high_current_out = ram_reg[A_PROG[3:0]][B_HC];

  // write acceptance by address and protection
  always_comb begin
    wr_ok = 1'b0;
    if (reg_addr_in <= A_PROG) begin
      wr_ok = !prot && load_done_reg && (reg_addr_in != A_PROG || zap_ok_s);
    end else if (reg_addr_in == A_TOS) begin
      wr_ok = 1'b1;
    end else if (reg_addr_in >= A_ID_WR_LO) begin
      wr_ok = !prot;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < CFG_BYTES; i++) begin
        ram_reg[i] <= BYTE_ZERO;
      end
      for (int i = 0; i < ID_FUSE_BYTES; i++) begin
        id_reg[i] <= BYTE_ZERO;
      end
      load_done_reg <= 1'b0;
    end else if (!load_done_reg) begin
      for (int i = 0; i < CFG_BYTES; i++) begin
        ram_reg[i] <= fuse_rd_data_in[8*i +: 8];
      end
      for (int i = 0; i < ID_FUSE_BYTES; i++) begin
        id_reg[i] <= fuse_rd_data_in[8*(CFG_BYTES+i) +: 8];
      end
      load_done_reg <= 1'b1;
    end else if (reg_wr_in && wr_ok) begin
      // mirror and status never match here, so writes to them do nothing
      if (reg_addr_in == A_PROG) begin
        ram_reg[A_PROG[3:0]][B_HC] <= reg_wdata_in[B_HC];
      end else if (reg_addr_in < A_PROG) begin
        ram_reg[reg_addr_in[3:0]] <= reg_wdata_in;
      end else if (reg_addr_in >= A_ID_WR_LO) begin
        id_reg[2'(reg_addr_in - A_ID_WR_LO)] <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tos_reg <= 1'b0;
    end else if (reg_wr_in && wr_ok && reg_addr_in == A_TOS) begin
      tos_reg <= reg_wdata_in[B_TOS];
    end
  end

  // read mux, zero outside the readable set
  always_comb begin
    rd_word = BYTE_ZERO;
    readable = !prot || reg_addr_in == A_PROF0 || reg_addr_in == A_PROF1 ||
               reg_addr_in >= A_OPEN_LO;
    if (reg_addr_in == A_PROG) begin
      rd_word = {ram_reg[A_PROG[3:0]][B_HC], 6'h00, zif.busy};
    end else if (reg_addr_in < A_PROG) begin
      rd_word = ram_reg[reg_addr_in[3:0]];
    end else if (reg_addr_in >= A_MIRROR_LO && reg_addr_in <= A_MIRROR_HI) begin
      rd_word = fuse_rd_data_in[8*reg_addr_in[3:0] +: 8];
    end else if (reg_addr_in == A_PROF0) begin
      rd_word = PROFILE_ID0;
    end else if (reg_addr_in == A_PROF1) begin
      rd_word = {3'b000, data_length_field};
    end else if (reg_addr_in == A_STATUS) begin
      rd_word = status_reg;
    end else if (reg_addr_in >= A_ID_LO && reg_addr_in < A_TOS) begin
      rd_word = ID_FIXED[8*(reg_addr_in[1:0]) +: 8];
    end else if (reg_addr_in == A_TOS) begin
      rd_word = {7'h00, tos_reg};
    end else if (reg_addr_in >= A_ID_WR_LO) begin
      rd_word = id_reg[2'(reg_addr_in - A_ID_WR_LO)];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= BYTE_ZERO;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= readable ? rd_word : BYTE_ZERO;
      end
    end
  end

  // master clock edges, frame start and end-of-frame timeout
  assign pos_req = idle_reg && ma_d_reg && !ma_s;
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ma_d_reg <= 1'b1;
      idle_reg <= 1'b1;
      cnt_reg <= '0;
      frame_start_out <= 1'b0;
      frame_error_bit_out <= 1'b1;
    end else begin
      ma_d_reg <= ma_s;
      frame_start_out <= pos_req;
      if (ma_s != ma_d_reg) begin
        cnt_reg <= '0;
        if (pos_req) begin
          idle_reg <= 1'b0;
          frame_error_bit_out <= !(|(status_reg & ERR_MASK));
        end
      end else if (!idle_reg) begin
        cnt_reg <= cnt_reg + 12'd1;
        if (cnt_reg >= tout_cyc - 12'd1) begin
          idle_reg <= 1'b1;
        end
      end
    end
  end
  assign link_busy_out = !idle_reg;

  // error pin: driven low for internal errors, outside pull-down seen as external error
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      error_out_pin_oe_out <= 1'b0;
      oe_hist_reg <= '0;
    end else begin
      error_out_pin_oe_out <= |(status_reg & DRIVE_MASK);
      oe_hist_reg <= {oe_hist_reg[EXT_MASK_CYC-2:0], error_out_pin_oe_out};
    end
  end
  assign error_out_pin_out = 1'b0;

  always_comb begin
    set_vec = BYTE_ZERO;
    set_vec[B_OK] = zif.done && !zif.fail;
    set_vec[B_FAIL] = zif.done && zif.fail;
    set_vec[B_SDATA] = pos_req && !startup_done;
    set_vec[B_AMAX] = amp_high_in;
    set_vec[B_AMIN] = amp_low_in;
    set_vec[B_EXT] = !err_pin_s && !error_out_pin_oe_out && !(|oe_hist_reg);
    // a new event wins over the read-clear in the same cycle
    status_next = (rd_status ? BYTE_ZERO : status_reg) | set_vec;
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_reg <= BYTE_ZERO;
    end else begin
      status_reg <= status_next;
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rstn_in);

  property p_read_clears;
    (rd_status && set_vec == BYTE_ZERO) |=> (status_reg == BYTE_ZERO);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status read did not clear");

  property p_set_wins;
    (rd_status && amp_high_in) |=> status_reg[B_AMAX];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

  property p_fail_flag;
    (zif.done && zif.fail) |=> (status_reg[B_FAIL] && !$past(rd_status) || status_reg[B_FAIL]);
  endproperty
  a_fail_flag: assert property (p_fail_flag) else $error("failure flag not set");

  property p_startup_err;
    (pos_req && !startup_done) |=> status_reg[B_SDATA];
  endproperty
  a_startup_err: assert property (p_startup_err) else $error("start-up error not set");

  property p_short_tout;
    tos_reg |-> (timeout_cycles_out == TOUT_SHORT_CYC);
  endproperty
  a_short_tout: assert property (p_short_tout) else $error("short timeout not chosen");

  property p_prot_write;
    (reg_wr_in && prot && load_done_reg && reg_addr_in == A_SCRATCH) |=>
      $stable(ram_reg[A_SCRATCH[3:0]]);
  endproperty
  a_prot_write: assert property (p_prot_write) else $error("protected write took effect");

  property p_prot_read;
    (reg_rd_in && prot && reg_addr_in < A_PROG) |=> (reg_rvalid_out && reg_rdata_out == BYTE_ZERO);
  endproperty
  a_prot_read: assert property (p_prot_read) else $error("protected read leaked data");

  property p_profile;
    (reg_rd_in && reg_addr_in == A_PROF0) |=> (reg_rdata_out == PROFILE_ID0);
  endproperty
  a_profile: assert property (p_profile) else $error("profile byte wrong");

  sequence s_req_with_error;
    pos_req && (|(status_reg & ERR_MASK));
  endsequence
  property p_frame_error;
    s_req_with_error |=> (frame_start_out && !frame_error_bit_out);
  endproperty
  a_frame_error: assert property (p_frame_error) else $error("frame error bit not low");

  sequence s_start_run;
    zif.start && !zif.busy && zif.supply_ok && zif.test_ok;
  endsequence
  property p_start_bit;
    s_start_run |=> ##1 (zif.busy && zap_strobe_out);
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("programming did not start");
endmodule

/* testbench/scsoc_master_model.sv */
// link master stand-in: produces the link clock for frames only
// assumes the slave samples this pin with its own system clock
`timescale 1ns/1ps
module scsoc_master_model #(
  parameter int HALF_NS = 80
) (
  output logic ma_clk_out
);
  // the clock stands high between frames
  initial ma_clk_out = 1'b1;
  task automatic frame(input int n);
    repeat (n) begin
      ma_clk_out = 1'b0;
      #(HALF_NS);
      ma_clk_out = 1'b1;
      #(HALF_NS);
    end
  endtask
endmodule

/* testbench/scsoc_top_tb_top.sv */
// self-checking bench for the register side of the position sensor
// assumes the link master model above and a shortened fuse pulse
`timescale 1ns/1ps
module scsoc_top_tb_top;
  import scsoc_pkg::*;
  logic clk_sys_in = 0, rstn_in = 0, wr = 0, rd = 0, pv = 1, ah = 0, al = 0, ext_low = 0;
  logic [6:0] addr = 0;
  logic [7:0] wd = 0, rdata, zdat, v;
  logic rvalid, ma_clk, fstart, ferr, busy, oe, po, hc, strobe, pin;
  logic [11:0] tcyc;
  logic [4:0] zidx;
  logic [8*FUSE_BYTES-1:0] fuse = '0;
  logic sup = 1;
  int error_cnt = 0, checks_done = 0, starts = 0, strobes = 0, dbl = 0;
  always #2 clk_sys_in = ~clk_sys_in;
  always @(negedge clk_sys_in) begin
    if (fstart === 1'b1) starts++;
  end
  // fuse array: each strobe burns the offered bits; counts strobes that hit an already burned bit
  always @(posedge strobe) begin
    strobes++;
    @(negedge clk_sys_in);
    if ((fuse[8*zidx +: 8] & zdat) != 8'h00) dbl++;
    fuse[8*zidx +: 8] = fuse[8*zidx +: 8] | zdat;
  end
  // open-drain wire: low when the device or an outside source pulls it
  assign pin = !(oe === 1'b1) && !ext_low;
  scsoc_master_model scsoc_master_model_inst (.ma_clk_out(ma_clk));
  scsoc_top #(.ZAP_PULSE_CYC(4)) scsoc_top_inst (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .reg_addr_in(addr), .reg_wdata_in(wd),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .ma_clk_in(ma_clk), .frame_start_out(fstart), .frame_error_bit_out(ferr),
    .link_busy_out(busy), .timeout_cycles_out(tcyc), .position_valid_in(pv),
    .amp_high_in(ah), .amp_low_in(al), .error_out_pin_in(pin), .error_out_pin_out(po),
    .error_out_pin_oe_out(oe), .zap_supply_ok_in(sup), .fuse_rd_data_in(fuse),
    .fuse_high_current_out(hc), .zap_strobe_out(strobe), .zap_index_out(zidx),
    .zap_data_out(zdat));
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk_sys_in);
    wr = 1'b0;
    @(negedge clk_sys_in);
  endtask
  task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk_sys_in);
    addr = a;
    rd = 1'b1;
    @(negedge clk_sys_in);
    rd = 1'b0;
    chk(rvalid, 1'b1);
    d = rdata;
    @(negedge clk_sys_in);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd_reg(a, d);
    chk(d, e);
  endtask
  task automatic frame();
    int n;
    for (n = 0; n < 1000 && busy !== 1'b0; n++) @(negedge clk_sys_in);
    if (n == 1000) begin
      error_cnt++;
      stop_test();
    end
    scsoc_master_model_inst.frame(4);
    repeat (6) @(negedge clk_sys_in);
  endtask
  task automatic do_reset();
    rstn_in = 1'b0;
    repeat (16) @(negedge clk_sys_in);
    rstn_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
  endtask
  task automatic t_map();
    chk(tcyc, 12'd4000);
    rd_chk(A_TOS, 8'h00);
    rd_chk(A_OEM_NIB, 8'h5A);
    rd_chk(A_ID_LO, 8'h67);
    rd_chk(A_ID_WR_LO, 8'h3C);
    wr_reg(A_ID_WR_LO, 8'h99);
    rd_chk(A_ID_WR_LO, 8'h99);
    wr_reg(A_MIRROR_LO, 8'hFF);
    rd_chk(A_MIRROR_LO, 8'h00);
    wr_reg(A_STATUS, 8'hFF);
    rd_chk(A_STATUS, 8'h00);
    wr_reg(A_SCRATCH, 8'hA5);
    rd_chk(A_SCRATCH, 8'hA5);
  endtask
  task automatic t_timeout();
    wr_reg(A_TOS, 8'h01);
    chk(tcyc, 12'd500);
    wr_reg(A_TOS, 8'h00);
    chk(tcyc, 12'd4000);
    wr_reg(A_CFG4, 8'h10);
    chk(tcyc, 12'd500);
    wr_reg(A_CFG4, 8'h00);
    wr_reg(A_TOS, 8'h01);
  endtask
  task automatic t_status();
    @(negedge clk_sys_in) ah = 1'b1;
    rd_chk(A_STATUS, 8'h04);
    @(negedge clk_sys_in) ah = 1'b0;
    frame();
    chk(ferr, 1'b0);
    chk({po, oe}, 2'b01);
    rd_chk(A_STATUS, 8'h04);
    rd_chk(A_STATUS, 8'h00);
    frame();
    chk(ferr, 1'b1);
    chk(starts, 2);
    @(negedge clk_sys_in) al = 1'b1;
    @(negedge clk_sys_in) al = 1'b0;
    rd_chk(A_STATUS, 8'h08);
    pv = 1'b0;
    frame();
    pv = 1'b1;
    rd_chk(A_STATUS, 8'h02);
    repeat (6) @(negedge clk_sys_in);
    ext_low = 1'b1;
    repeat (8) @(negedge clk_sys_in);
    ext_low = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    rd_chk(A_STATUS, 8'h10);
  endtask
  task automatic t_prog();
    int n;
    wr_reg(A_OEM_NIB, 8'h00);
    wr_reg(A_ID_WR_LO, 8'h81);
    wr_reg(A_TEST, 8'h00);
    wr_reg(A_PROG, 8'h01);
    wr_reg(A_PROG, 8'h01);
    v = 8'h01;
    for (n = 0; n < 100 && v[0] !== 1'b0; n++) rd_reg(A_PROG, v);
    if (n == 100) begin
      error_cnt++;
      stop_test();
    end
    chk(v, 8'h00);
    chk(strobes, FUSE_BYTES);
    chk(dbl, 0);
    chk(fuse[135:128], 8'hBD);
    rd_chk(A_STATUS, 8'h01);
    rd_chk(7'h1D, 8'h00);
    wr_reg(A_TEST, 8'h01);
    wr_reg(A_PROG, 8'h01);
    repeat (4) @(negedge clk_sys_in);
    rd_chk(A_STATUS, 8'h80);
    wr_reg(A_TEST, 8'h00);
    wr_reg(A_PROG, 8'h80);
    chk(hc, 1'b1);
    rd_chk(7'h1A, 8'h5A);
    wr_reg(A_PROG, 8'h00);
    chk(hc, 1'b0);
    rd_chk(7'h1A, 8'h5A);
    sup = 1'b0;
    repeat (3) @(negedge clk_sys_in);
    wr_reg(A_PROG, 8'h01);
    rd_chk(A_PROG, 8'h00);
    rd_chk(A_STATUS, 8'h00);
    sup = 1'b1;
    repeat (3) @(negedge clk_sys_in);
  endtask
  task automatic t_protect();
    wr_reg(A_RES, 8'h82);
    wr_reg(A_CFG5, 8'h40);
    wr_reg(A_SCRATCH, 8'h11);
    rd_chk(A_SCRATCH, 8'h00);
    rd_chk(A_PROF0, 8'h2C);
    rd_chk(A_PROF1, 8'h0C);
    wr_reg(A_ID_WR_LO, 8'h55);
    rd_chk(A_ID_WR_LO, 8'h81);
    wr_reg(A_TOS, 8'h00);
    chk(tcyc, 12'd4000);
    rd_chk(A_TOS, 8'h00);
  endtask
  initial begin
    fuse[87:80] = 8'h5A;
    fuse[135:128] = 8'h3C;
    do_reset();
    t_map();
    t_timeout();
    t_status();
    t_prog();
    t_protect();
    stop_test();
  end
endmodule
